//--- rtl/sfc_regs.vh
// constants and functional notes for the serial-frame converter control block
// Functional notes
// R1: sample input difference at select falling edge, then convert on serial clock.
// R2: isolate inputs while converting, reconnect and acquire once conversion finishes.
// R3: results are unsigned straight binary, 12 bits wide.
// R4: code 000 at low end, 800 at mid scale, fff at full scale.
// R5: a frame runs from select falling edge to next select rising edge.
// R6: host waits 15 ns after select falls before first clock falling edge.
// R7: first zero at select fall, then another zero and result bits per falling edge.
// R8: after fourteenth falling edge, data out stays low while select is low.
// R9: select rising edge ends frame and releases data out to high impedance.
// R10: host allows 200 ns acquisition after conversion before next sample.
// R11: host keeps 10 ns from last clock falling edge to select rise.
// R12: first frame after power-up runs offset calibration with data out held low.
// R13: calibration stores offset only with at least 16 falling edges in frame.
// R14: offset register clears at power-up and is not serially accessible.
// R15: later results are corrected by the stored offset.
// R16: inputs stay disconnected while calibration runs.
// R17: host limits calibration clock to 16 MHz or 12 MHz by supply.
// R18: host keeps select high for acquisition time after calibration frame.
// R19: only power cycling restores calibration result and power-up state.
// R20: host supplies 16 MHz serial clock for full sample rate.
// R21: result bits leave most significant bit first.
`ifndef SFC_REGS_VH
`define SFC_REGS_VH
`define SFC_RES_BITS 12
`define SFC_CODE_NFS 12'h000
`define SFC_CODE_MID 12'h800
`define SFC_CODE_PFS 12'hfff
`define SFC_LAST_DATA_EDGE 5'h0e
`define SFC_CAL_EDGES 5'h10
`define SFC_OFFSET_RST 12'h000
`define SFC_FIFO_DEPTH 16
`define SFC_ACQ_TIME_NS 200
`define SFC_CLK_PERIOD_NS 100
`define SFC_ACQ_CYCLES ((`SFC_ACQ_TIME_NS + `SFC_CLK_PERIOD_NS - 1) / `SFC_CLK_PERIOD_NS)
`endif

//--- rtl/sfc_sync.v
// two-flop synchroniser for one level input
`timescale 1ns/1ps
module sfc_sync #(
	// level held through reset; matches the idle level of the pin
	parameter [0:0] RST_VAL = 1'b0
) (
	// clock and reset
	input wire mclk,
	input wire nrst,
	// level
	input wire din,
	output reg dout
);
	reg stage1;
	always @(posedge mclk) begin
		if (!nrst) begin
			stage1 <= RST_VAL;
			dout <= RST_VAL;
		end else begin
			stage1 <= din;
			dout <= stage1;
		end
	end
endmodule // sfc_sync

//--- rtl/sfc_fifo.v
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module sfc_fifo #(
	parameter WIDTH = 12,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	// clock and reset
	input wire mclk,
	input wire nrst,
	// write side
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	// read side
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wptr;
	reg [AW-1:0] rptr;
	reg [AW:0] count;
	wire do_wr;
	wire do_rd;
	assign in_ready = (count != DEPTH[AW:0]);
	assign out_valid = (count != {(AW+1){1'b0}});
	assign out_data = mem[rptr];
	assign do_wr = in_valid && in_ready;
	assign do_rd = out_valid && out_ready;
	always @(posedge mclk) begin
		if (do_wr) begin
			mem[wptr] <= in_data;
		end
	end
	always @(posedge mclk) begin
		if (!nrst) begin
			wptr <= {AW{1'b0}};
			rptr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
		end else begin
			if (do_wr) begin
				wptr <= wptr + 1'b1;
			end
			if (do_rd) begin
				rptr <= rptr + 1'b1;
			end
			if (do_wr && !do_rd) begin
				count <= count + 1'b1;
			end else if (do_rd && !do_wr) begin
				count <= count - 1'b1;
			end
		end
	end
endmodule // sfc_fifo

//--- rtl/sfc_ctrl.v
// frame, conversion and offset-calibration control of the serial converter
`timescale 1ns/1ps
`include "sfc_regs.vh"
module sfc_ctrl #(
	parameter RES = `SFC_RES_BITS,
	parameter DEPTH = `SFC_FIFO_DEPTH
) (
	// clock and power-up reset
	input wire mclk,
	input wire nrst,
	// serial link pins from host
	input wire cs_n,
	input wire sclk,
	// serial data out, three-state: value and enable
	output reg sdo_o,
	output reg sdo_oe,
	// analog front end: raw quantiser result and offset sample
	input wire [RES-1:0] raw_code,
	input wire [RES-1:0] offset_sample,
	output reg input_connect,
	output reg sample_hold,
	// result stream, one corrected code per conversion frame reaching the fourteenth falling edge while the fifo has room
	output reg res_valid,
	input wire res_ready,
	output reg [RES-1:0] res_data,
	// status
	output reg calibrated,
	output reg calibrating,
	output reg overflow
);
	localparam ST_IDLE = 4'b0001;
	localparam ST_CONV = 4'b0010;
	localparam ST_CAL = 4'b0100;
	localparam ST_TAIL = 4'b1000;
	localparam [RES-1:0] CODE_MAX = `SFC_CODE_PFS;
	localparam [RES-1:0] CODE_MIN = `SFC_CODE_NFS;

	// offset-corrected code, clamped to the code at the low end of the range
	function [RES-1:0] correct;
		input [RES-1:0] raw;
		input [RES-1:0] ofs;
		reg [RES:0] diff;
		begin
			diff = {1'b0, raw} - {1'b0, ofs};
			if (diff[RES]) begin
				correct = CODE_MIN;
			end else begin
				correct = diff[RES-1:0];
			end
		end
	endfunction

	wire cs_s;
	wire sclk_s;
	reg cs_d;
	reg sclk_d;
	wire cs_fall;
	wire cs_rise;
	wire sclk_fall;
	reg [3:0] state;
	reg [3:0] next_state;
	reg first_frame;
	reg [4:0] edge_cnt;
	reg [RES-1:0] offset_correction_register;
	reg [RES-1:0] shift;
	reg [RES-1:0] held_code;
	reg [1:0] acq_cnt;
	reg f_valid;
	wire f_ready;
	reg [RES-1:0] f_data;
	wire q_valid;
	wire [RES-1:0] q_data;

	// select idles high, so its synchroniser resets high: no false frame after reset
	sfc_sync #(
		.RST_VAL(1'b1)
	) u_cs (
		.mclk(mclk),
		.nrst(nrst),
		.din(cs_n),
		.dout(cs_s)
	);
	sfc_sync u_sclk (
		.mclk(mclk),
		.nrst(nrst),
		.din(sclk),
		.dout(sclk_s)
	);

	assign cs_fall = cs_d && !cs_s;
	assign cs_rise = !cs_d && cs_s;
	assign sclk_fall = sclk_d && !sclk_s && !cs_s;

	always @(posedge mclk) begin
		if (!nrst) begin
			cs_d <= 1'b1;
			sclk_d <= 1'b0;
		end else begin
			cs_d <= cs_s;
			sclk_d <= sclk_s;
		end
	end

	always @* begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (cs_fall) begin
					next_state = first_frame ? ST_CAL : ST_CONV; // [R1] [R5] [R12]
				end
			end
			ST_CONV: begin
				if (cs_rise) begin
					next_state = ST_IDLE; // [R5] [R9]
				end else if (sclk_fall && edge_cnt == `SFC_LAST_DATA_EDGE - 5'h1) begin
					next_state = ST_TAIL;
				end
			end
			ST_CAL: begin
				if (cs_rise) begin
					next_state = ST_IDLE;
				end else if (sclk_fall && edge_cnt == `SFC_CAL_EDGES - 5'h1) begin
					next_state = ST_TAIL;
				end
			end
			ST_TAIL: begin
				if (cs_rise) begin
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always @(posedge mclk) begin
		if (!nrst) begin
			state <= ST_IDLE;
			first_frame <= 1'b1;
			edge_cnt <= 5'h00;
			offset_correction_register <= `SFC_OFFSET_RST; // [R14] [R19]
			shift <= {RES{1'b0}};
			held_code <= {RES{1'b0}};
			res_valid <= 1'b0;
			res_data <= {RES{1'b0}};
			sdo_o <= 1'b0;
			sdo_oe <= 1'b0;
			input_connect <= 1'b1;
			sample_hold <= 1'b0;
			acq_cnt <= 2'h0;
			f_valid <= 1'b0;
			f_data <= {RES{1'b0}};
			calibrated <= 1'b0;
			calibrating <= 1'b0;
			overflow <= 1'b0;
		end else begin
			state <= next_state;
			f_valid <= 1'b0;
			sample_hold <= 1'b0;
			if (cs_fall) begin
				edge_cnt <= 5'h00;
				sdo_o <= 1'b0; // [R7]
				sdo_oe <= 1'b1;
				input_connect <= 1'b0; // [R2] [R16]
				if (first_frame) begin
					first_frame <= 1'b0; // [R12]
					calibrating <= 1'b1;
				end else begin
					sample_hold <= 1'b1; // [R1]
					held_code <= raw_code; // [R1]
					shift <= correct(raw_code, offset_correction_register); // [R15] [R3] [R4]
				end
			end else if (cs_rise) begin
				sdo_oe <= 1'b0; // [R9]
				sdo_o <= 1'b0;
				calibrating <= 1'b0;
				// a cut frame, conversion or calibration, still hands the inputs back
				input_connect <= 1'b1; // [R2] [R16]
			end else if (sclk_fall) begin
				if (edge_cnt != 5'h1f) begin
					edge_cnt <= edge_cnt + 5'h01;
				end
				case (state)
					ST_CONV: begin
						if (edge_cnt == 5'h00) begin
							sdo_o <= 1'b0; // [R7]
						end else begin
							sdo_o <= shift[RES-1]; // [R21]
							shift <= {shift[RES-2:0], 1'b0};
						end
						if (edge_cnt == `SFC_LAST_DATA_EDGE - 5'h1) begin
							sdo_o <= 1'b0; // [R8]
							input_connect <= 1'b1; // [R2]
							f_valid <= 1'b1;
							f_data <= correct(held_code, offset_correction_register); // [R15]
							if (!f_ready) begin
								overflow <= 1'b1;
							end
						end
					end
					ST_CAL: begin
						sdo_o <= 1'b0; // [R12]
						if (edge_cnt == `SFC_CAL_EDGES - 5'h1) begin
							offset_correction_register <= offset_sample; // [R13]
							calibrated <= 1'b1;
							calibrating <= 1'b0;
							input_connect <= 1'b1; // [R16]
						end
					end
					default: begin
						sdo_o <= 1'b0; // [R8]
					end
				endcase
			end
			if (state == ST_IDLE && !input_connect && !cs_fall) begin
				if (acq_cnt != 2'h3) begin
					acq_cnt <= acq_cnt + 2'h1;
				end
			end else begin
				acq_cnt <= 2'h0;
			end
			if (q_valid && res_ready && res_valid) begin
				res_valid <= 1'b0;
			end
			if (q_valid && (!res_valid || res_ready)) begin
				res_valid <= 1'b1;
				res_data <= q_data;
			end else if (res_ready) begin
				res_valid <= 1'b0;
			end
		end
	end

	sfc_fifo #(
		.WIDTH(RES),
		.DEPTH(DEPTH),
		.AW(4)
	) u_fifo (
		.mclk(mclk),
		.nrst(nrst),
		.in_valid(f_valid),
		.in_ready(f_ready),
		.in_data(f_data),
		.out_valid(q_valid),
		.out_ready(!res_valid || res_ready),
		.out_data(q_data)
	);
endmodule // sfc_ctrl

//--- tb/sfc_ctrl_properties.sv
// concurrent checks on the converter control ports
`timescale 1ns/1ps
module sfc_ctrl_properties #(
	parameter RES = 12,
	parameter DEPTH = 16
) (
	// clock and reset
	input wire mclk,
	input wire nrst,
	// serial pins
	input wire cs_n,
	input wire sclk,
	input wire sdo_o,
	input wire sdo_oe,
	// front end
	input wire [RES-1:0] raw_code,
	input wire [RES-1:0] offset_sample,
	input wire input_connect,
	input wire sample_hold,
	// stream and status
	input wire res_valid,
	input wire res_ready,
	input wire [RES-1:0] res_data,
	input wire calibrated,
	input wire calibrating,
	input wire overflow
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);
	AST_OE_ON: assert property ($fell(cs_n) |-> ##[2:6] (sdo_oe && !sdo_o))
		else $error("data out not driven low after select fall");
	AST_OE_OFF: assert property ($rose(cs_n) |-> ##[2:6] !sdo_oe)
		else $error("data out not released after select rise");
	AST_IDLE: assert property (cs_n [*6] |-> !sdo_oe)
		else $error("data out driven outside a frame");
	AST_CAL_LOW: assert property (calibrating |-> !sdo_o)
		else $error("data out high during calibration");
	AST_CAL_ISO: assert property (calibrating |-> !input_connect)
		else $error("inputs connected during calibration");
	AST_SAMPLE: assert property (sample_hold |=> !input_connect && !calibrating)
		else $error("inputs not isolated after sampling");
	AST_ACQ: assert property (cs_n [*8] |-> input_connect)
		else $error("inputs not reconnected after frame");
	AST_KEEP: assert property (!$fell(calibrated))
		else $error("calibration result lost");
	AST_STORE: assert property ($rose(calibrated) |-> $past(calibrating))
		else $error("offset stored outside calibration");
	AST_HOLD: assert property (res_valid && !res_ready |=> res_valid && $stable(res_data))
		else $error("result changed while stalled");
endmodule // sfc_ctrl_properties
bind sfc_ctrl sfc_ctrl_properties #(.RES(RES), .DEPTH(DEPTH)) u_props (.mclk(mclk), .nrst(nrst),
	.cs_n(cs_n), .sclk(sclk), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .raw_code(raw_code),
	.offset_sample(offset_sample), .input_connect(input_connect), .sample_hold(sample_hold),
	.res_valid(res_valid), .res_ready(res_ready), .res_data(res_data),
	.calibrated(calibrated), .calibrating(calibrating), .overflow(overflow));

//--- tb/sfc_host.sv
// host controller model driving select and serial clock, capturing data out
`timescale 1ns/1ps
module sfc_host (
	// clock
	input wire mclk,
	// serial pins
	output reg cs_n,
	output reg sclk,
	input wire sdo_o,
	input wire sdo_oe
);
	reg last;
	// released line shows the inverse of its last value
	wire sdo = sdo_oe ? sdo_o : ~last;
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		last = 1'b0;
	end
	always @(posedge mclk) begin
		if (sdo_oe)
			last <= sdo_o;
	end
	// one frame of n falling edges; word gathers n+1 values, first one oldest
	task frame(input integer n, output [31:0] word);
		integer j;
		begin
			word = 32'h0;
			cs_n <= 1'b0;
			repeat (4) @(posedge mclk);
			for (j = 0; j < n; j = j + 1) begin
				sclk <= 1'b1;
				repeat (4) @(posedge mclk);
				word = {word[30:0], sdo};
				sclk <= 1'b0;
				repeat (4) @(posedge mclk);
			end
			repeat (4) @(posedge mclk);
			word = {word[30:0], sdo};
			cs_n <= 1'b1;
			repeat (12) @(posedge mclk);
		end
	endtask
endmodule // sfc_host

//--- tb/sar_adc_serial_frame_offset_cal_tb.sv
// self-checking bench of the converter control block
`timescale 1ns/1ps
module sar_adc_serial_frame_offset_cal_tb;
	reg mclk = 1'b0;
	reg nrst = 1'b0;
	reg res_ready = 1'b0;
	reg [11:0] raw_code = 12'h000;
	reg [11:0] offset_sample = 12'h000;
	wire cs_n, sclk, sdo_o, sdo_oe, input_connect, sample_hold, res_valid;
	wire calibrated, calibrating, overflow;
	wire [11:0] res_data;
	integer failures = 0;
	integer n_checks = 0;
	integer cyc = 0;
	integer i, k;
	reg [31:0] w;
	always #50 mclk = ~mclk;
	sfc_host host (.mclk(mclk), .cs_n(cs_n), .sclk(sclk), .sdo_o(sdo_o), .sdo_oe(sdo_oe));
	sfc_ctrl DUT (.mclk(mclk), .nrst(nrst), .cs_n(cs_n), .sclk(sclk), .sdo_o(sdo_o),
		.sdo_oe(sdo_oe), .raw_code(raw_code), .offset_sample(offset_sample),
		.input_connect(input_connect), .sample_hold(sample_hold), .res_valid(res_valid),
		.res_ready(res_ready), .res_data(res_data), .calibrated(calibrated),
		.calibrating(calibrating), .overflow(overflow));
	task conclude;
		if (failures == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input string nm, input [31:0] seen, input [31:0] exp);
		n_checks = n_checks + 1;
		if (seen !== exp) begin
			failures = failures + 1;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task rst;
		nrst <= 1'b0;
		repeat (20) @(posedge mclk);
		nrst <= 1'b1;
		@(posedge mclk);
	endtask
	task pop(input [11:0] exp);
		i = 0;
		while (res_valid !== 1'b1 && i < 40) begin
			@(posedge mclk);
			i = i + 1;
		end
		chk("res_valid", {31'h0, res_valid}, 32'h1);
		chk("res_data", {20'h0, res_data}, {20'h0, exp});
		res_ready <= 1'b1;
		@(posedge mclk);
		res_ready <= 1'b0;
		@(posedge mclk);
	endtask
	// normal frame: serial word and stream both carry the corrected code
	task nf(input [11:0] code, input [11:0] exp);
		raw_code <= code;
		host.frame(16, w);
		chk("sdo word", w, {17'h0, exp, 3'h0});
		pop(exp);
	endtask
	initial begin
		offset_sample <= 12'h005;
		rst;
		raw_code <= 12'h0aa;
		host.frame(10, w);
		chk("short cal word", w, 32'h0);
		chk("calibrated", {31'h0, calibrated}, 32'h0);
		nf(12'h000, 12'h000);
		nf(12'h800, 12'h800);
		nf(12'hfff, 12'hfff);
		rst;
		host.frame(16, w);
		chk("cal word", w, 32'h0);
		chk("calibrated", {31'h0, calibrated}, 32'h1);
		nf(12'h800, 12'h7fb);
		nf(12'h003, 12'h000);
		// output stage plus 16 buffered words fill up; the eighteenth result overflows
		for (k = 0; k < 18; k = k + 1) begin
			raw_code <= 12'h010 + k;
			host.frame(14, w);
			chk("short sdo word", w, {19'h0, 12'h00b + k[11:0], 1'b0});
		end
		chk("overflow", {31'h0, overflow}, 32'h1);
		for (k = 0; k < 17; k = k + 1)
			pop(12'h00b + k);
		chk("res_valid", {31'h0, res_valid}, 32'h0);
		conclude;
	end
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures = failures + 1;
			conclude;
		end
	end
endmodule // sar_adc_serial_frame_offset_cal_tb
